// file: inc/ccp_pkg.sv
// Purpose: shared constants for the capture/compare time base and auto-shutdown
// Assumes: 32-bit axi4-lite register bus, byte addresses
// Notes: pin index 0..3 stands for outputs a, b, c, d
package ccp_pkg;
	// ==========================================
	// register byte offsets
	localparam logic [7:0] OFF_TIMER = 8'h00;
	localparam logic [7:0] OFF_CMP = 8'h04;
	localparam logic [7:0] OFF_CTRL = 8'h08;
	localparam logic [7:0] OFF_SHUT = 8'h0c;
	localparam logic [7:0] OFF_PER = 8'h10;
	localparam logic [7:0] OFF_DUTY = 8'h14;
	localparam logic [7:0] OFF_ISTS = 8'h18;
	localparam logic [7:0] OFF_IMASK = 8'h1c;
	// ==========================================
	// control register fields
	localparam int CTRL_RUN = 0;
	localparam int CTRL_MODE = 1;
	localparam int CTRL_CAP_RISE = 3;
	localparam int CTRL_AUTO_RST = 4;
	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_CAPTURE = 2'h1;
	localparam logic [1:0] MODE_COMPARE = 2'h2;
	localparam logic [1:0] MODE_SPECIAL = 2'h3;
	// ==========================================
	// auto-shutdown register fields
	localparam int SHUT_EVENT = 7;
	localparam int SHUT_EXT_EN = 6;
	localparam int SHUT_B4_EN = 4;
	localparam int SHUT_AC = 2;
	localparam int SHUT_BD = 0;
	localparam logic [7:0] SHUT_RESET = 8'h00;
	localparam logic [7:0] SHUT_WMASK = 8'h5f;
	localparam logic [1:0] PSS_LOW = 2'h0;
	localparam logic [1:0] PSS_HIGH = 2'h1;
	// ==========================================
	// interrupt status bits
	localparam int IRQ_OVF = 0;
	localparam int IRQ_CCP = 1;
	localparam int IRQ_SHUT = 2;
	localparam int IRQ_W = 3;
	// ==========================================
	// reset values and bus answers
	localparam logic [15:0] TIMER_RESET = 16'h0000;
	localparam logic [15:0] PER_RESET = 16'h00ff;
	localparam logic [15:0] DUTY_RESET = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		PWM_RUN = 3'b001,
		PWM_SHUT = 3'b010,
		PWM_WAIT = 3'b100
	} pwm_state_e;
endpackage : ccp_pkg

// file: rtl/ccp_pin_drive.sv
// Purpose: registered drive of the four pwm pins with shutdown safe states
// Assumes: pin index 0..3 is a, b, c, d; a/c and b/d form the two pairs
// Notes: high impedance is shown only as output enable low
`timescale 1ns/1ps
`default_nettype none
module ccp_pin_drive import ccp_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	input wire logic pwm_level,
	input wire logic shut_active,
	input wire logic [1:0] pss_ac,
	input wire logic [1:0] pss_bd,
	output logic [3:0] pin_out,
	output logic [3:0] pin_oe
);
	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} drive_s;
	drive_s q, d;
	logic [1:0] drv [4];

	// ==========================================
	// per pin decode, {oe, out}
	function automatic logic [1:0] pin_drive(input logic shut, input logic lvl, input logic [1:0] code);
		logic [1:0] r;
		r = {1'b1, lvl};
		if (shut) begin
			if (code[1]) begin
				r = 2'b00;
			end else if (code == PSS_HIGH) begin
				r = 2'b11;
			end else begin
				r = 2'b10;
			end
		end
		return r;
	endfunction : pin_drive

	for (genvar i = 0; i < 4; i++) begin : g_pin
		// a/c follow the level, b/d its complement
		assign drv[i] = pin_drive(shut_active, (i % 2 == 0) ? pwm_level : ~pwm_level, (i % 2 == 0) ? pss_ac : pss_bd);
	end

	always_comb begin
		d = q;
		for (int j = 0; j < 4; j++) begin
			d.oe[j] = drv[j][1];
			d.out[j] = drv[j][0];
		end
	end

	// safe default: all pins released until the first enabled edge
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign pin_out = q.out;
	assign pin_oe = q.oe;

	a_bd_tristate: assert property (@(posedge clk_sys) disable iff (reset)
		ce && shut_active && pss_bd[1] |=> !pin_oe[1] && !pin_oe[3])
		else $error("b/d pins driven while shutdown asks tri-state");
	a_ac_levels: assert property (@(posedge clk_sys) disable iff (reset)
		ce && shut_active && pss_ac == PSS_LOW |=> pin_oe[0] && pin_oe[2] && !pin_out[0] && !pin_out[2])
		else $error("a/c pins not driven low in shutdown");
endmodule : ccp_pin_drive
`default_nettype wire

// file: rtl/ccp_timebase_autoshutdown.sv
// Purpose: capture/compare on the base timer, special event clear, pwm auto-shutdown
// Assumes: axi4-lite slave, fault and capture pins asynchronous to clk_sys
// Notes: ce low freezes every flop and holds all bus ready signals low
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - capture and compare use the 16-bit base timer as time base
// - a capture event copies the timer into the capture/compare pair
// - compare raises an event when capture/compare equals the timer
// - special event trigger mode clears the timer on a match
// - special event clear never sets the timer overflow flag
// - a timer write in the clear cycle wins and the clear is dropped
// - shutdown is level based while an enabled fault input stays low
// - shutdown flag set during shutdown; writes ignored while a fault persists
// - pwm resumes only at the start of the next period
// - bd code 1x tri-states outputs b and d in shutdown
module ccp_timebase_autoshutdown import ccp_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic capture_pin,
	input wire logic ext_int_pin,
	input wire logic pin_b4,
	output logic pwm_out_a,
	output logic pwm_oe_a,
	output logic pwm_out_b,
	output logic pwm_oe_b,
	output logic pwm_out_c,
	output logic pwm_oe_c,
	output logic pwm_out_d,
	output logic pwm_oe_d,
	output logic irq
);
	typedef struct packed {
		logic [15:0] timer;
		logic [15:0] cmp;
		logic [4:0] ctrl;
		logic [7:0] shut;
		logic [15:0] per;
		logic [15:0] duty;
		logic [15:0] pcnt;
		pwm_state_e state;
		logic [IRQ_W-1:0] ists;
		logic [IRQ_W-1:0] imask;
		logic irq;
		logic aw_have;
		logic [7:0] awaddr;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic cap_s1, cap_s2, cap_s3;
		logic int_s1, int_s2;
		logic b4_s1, b4_s2;
	} state_s;
	state_s q, d;

	logic wr_go, tw_lo, tw_hi, tick, match, special, cap_edge, fault, per_start;
	logic [1:0] mode;
	logic [3:0] pin_out, pin_oe;

	// ==========================================
	// address decode
	function automatic logic reg_mapped(input logic [7:0] a);
		return a[1:0] == 2'b00 && a[7:5] == 3'b000;
	endfunction : reg_mapped

	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction : reg_hit

	// ==========================================
	// combinational helpers
	assign s_axi_awready = ce & ~q.aw_have & ~q.bvalid;
	assign s_axi_wready = ce & ~q.w_have & ~q.bvalid;
	assign s_axi_arready = ce & ~q.rvalid;
	assign wr_go = q.aw_have & q.w_have & ~q.bvalid;
	assign tw_lo = wr_go & reg_hit(q.awaddr, OFF_TIMER) & q.wstrb[0];
	assign tw_hi = wr_go & reg_hit(q.awaddr, OFF_TIMER) & q.wstrb[1];
	assign mode = q.ctrl[CTRL_MODE +: 2];
	assign tick = q.ctrl[CTRL_RUN];
	assign match = tick & mode[1] & (q.timer == q.cmp);
	assign special = match & (mode == MODE_SPECIAL);
	// edge detect reads stages two and three only
	assign cap_edge = q.ctrl[CTRL_CAP_RISE] ? (q.cap_s2 & ~q.cap_s3) : (~q.cap_s2 & q.cap_s3);
	// fault inputs are active low levels
	assign fault = (q.shut[SHUT_EXT_EN] & ~q.int_s2) | (q.shut[SHUT_B4_EN] & ~q.b4_s2);
	assign per_start = q.pcnt == q.per;

	always_comb begin
		logic [16:0] inc;
		logic [IRQ_W-1:0] set;
		inc = {1'b0, q.timer} + 17'h00001;
		set = '0;
		d = q;
		// ==========================================
		// pin synchronisers
		d.cap_s1 = capture_pin;
		d.cap_s2 = q.cap_s1;
		d.cap_s3 = q.cap_s2;
		d.int_s1 = ext_int_pin;
		d.int_s2 = q.int_s1;
		d.b4_s1 = pin_b4;
		d.b4_s2 = q.b4_s1;

		// ==========================================
		// bus write channel
		if (s_axi_awvalid & s_axi_awready) begin
			d.aw_have = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid & s_axi_wready) begin
			d.w_have = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (q.bvalid & s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (wr_go) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = reg_mapped(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
		end

		// ==========================================
		// base timer
		if (tick) begin
			if (special) begin
				d.timer = '0;
			end else begin
				d.timer = inc[15:0];
				set[IRQ_OVF] = inc[16];
			end
		end
		if (tw_lo | tw_hi) begin
			// write wins, any pending clear or count is dropped
			d.timer = q.timer;
			if (tw_lo) begin
				d.timer[7:0] = q.wdata[7:0];
			end
			if (tw_hi) begin
				d.timer[15:8] = q.wdata[15:8];
			end
		end

		// ==========================================
		// capture and compare
		if (match) begin
			set[IRQ_CCP] = 1'b1;
		end
		if (mode == MODE_CAPTURE && cap_edge) begin
			d.cmp = q.timer;
			set[IRQ_CCP] = 1'b1;
		end

		// ==========================================
		// register writes
		if (wr_go) begin
			case (q.awaddr)
				OFF_CMP: begin
					if (q.wstrb[0]) begin
						d.cmp[7:0] = q.wdata[7:0];
					end
					if (q.wstrb[1]) begin
						d.cmp[15:8] = q.wdata[15:8];
					end
				end
				OFF_CTRL: begin
					if (q.wstrb[0]) begin
						d.ctrl = q.wdata[4:0];
					end
				end
				OFF_SHUT: begin
					if (q.wstrb[0]) begin
						d.shut = (q.wdata[7:0] & SHUT_WMASK) | (q.shut & ~SHUT_WMASK);
						if (!fault) begin
							d.shut[SHUT_EVENT] = q.wdata[SHUT_EVENT];
						end
					end
				end
				OFF_PER: begin
					d.per = q.wdata[15:0];
				end
				OFF_DUTY: begin
					d.duty = q.wdata[15:0];
				end
				OFF_ISTS: begin
					d.ists = q.ists & ~q.wdata[IRQ_W-1:0];
				end
				OFF_IMASK: begin
					d.imask = q.wdata[IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// ==========================================
		// auto-shutdown flag
		if (fault) begin
			d.shut[SHUT_EVENT] = 1'b1;
		end else if (q.ctrl[CTRL_AUTO_RST] && q.shut[SHUT_EVENT] && !(wr_go && reg_hit(q.awaddr, OFF_SHUT))) begin
			d.shut[SHUT_EVENT] = 1'b0;
		end
		set[IRQ_SHUT] = d.shut[SHUT_EVENT] & ~q.shut[SHUT_EVENT];
		// set wins over a same-cycle clear
		d.ists = d.ists | set;
		d.irq = |(q.ists & q.imask);

		// ==========================================
		// pwm period and restart sequencing
		d.pcnt = per_start ? 16'h0000 : q.pcnt + 16'h0001;
		case (q.state)
			PWM_RUN: begin
				if (q.shut[SHUT_EVENT]) begin
					d.state = PWM_SHUT;
				end
			end
			PWM_SHUT: begin
				if (!q.shut[SHUT_EVENT]) begin
					d.state = PWM_WAIT;
				end
			end
			PWM_WAIT: begin
				if (q.shut[SHUT_EVENT]) begin
					d.state = PWM_SHUT;
				end else if (per_start) begin
					d.state = PWM_RUN;
				end
			end
			default: begin
				d.state = PWM_SHUT;
			end
		endcase

		// ==========================================
		// bus read channel
		if (q.rvalid & s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid & s_axi_arready) begin
			d.rvalid = 1'b1;
			d.rresp = reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				OFF_TIMER: d.rdata = {16'h0000, q.timer};
				OFF_CMP: d.rdata = {16'h0000, q.cmp};
				OFF_CTRL: d.rdata = {27'h0000000, q.ctrl};
				OFF_SHUT: d.rdata = {24'h000000, q.shut};
				OFF_PER: d.rdata = {16'h0000, q.per};
				OFF_DUTY: d.rdata = {16'h0000, q.duty};
				OFF_ISTS: d.rdata = {29'h00000000, q.ists};
				OFF_IMASK: d.rdata = {29'h00000000, q.imask};
				default: d.rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			q <= '0;
			q.timer <= TIMER_RESET;
			q.ctrl <= CTRL_RESET;
			q.shut <= SHUT_RESET;
			q.per <= PER_RESET;
			q.duty <= DUTY_RESET;
			q.state <= PWM_RUN;
			// idle fault pins read high, so no shutdown straight out of reset
			q.int_s1 <= 1'b1;
			q.int_s2 <= 1'b1;
			q.b4_s1 <= 1'b1;
			q.b4_s2 <= 1'b1;
		end else if (ce) begin
			q <= d;
		end
	end

	// ==========================================
	// pin drive
	ccp_pin_drive u_drive (
		.clk_sys(clk_sys),
		.reset(reset),
		.ce(ce),
		.pwm_level(q.pcnt < q.duty),
		.shut_active(q.state != PWM_RUN),
		.pss_ac(q.shut[SHUT_AC +: 2]),
		.pss_bd(q.shut[SHUT_BD +: 2]),
		.pin_out(pin_out),
		.pin_oe(pin_oe)
	);

	assign {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a} = pin_out;
	assign {pwm_oe_d, pwm_oe_c, pwm_oe_b, pwm_oe_a} = pin_oe;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign irq = q.irq;

	// ==========================================
	// checks
	a_timer_count: assert property (@(posedge clk_sys) disable iff (reset)
		ce && tick && !special && !tw_lo && !tw_hi |=> q.timer == $past(q.timer) + 16'h0001)
		else $error("timer did not advance by one");
	a_capture_copy: assert property (@(posedge clk_sys) disable iff (reset)
		ce && mode == MODE_CAPTURE && cap_edge && !(wr_go && q.awaddr == OFF_CMP) |=> q.cmp == $past(q.timer))
		else $error("capture did not copy the timer");
	a_compare_flag: assert property (@(posedge clk_sys) disable iff (reset)
		ce && match |=> q.ists[IRQ_CCP])
		else $error("compare match did not raise its flag");
	a_special_clear: assert property (@(posedge clk_sys) disable iff (reset)
		ce && special && !tw_lo && !tw_hi |=> q.timer == 16'h0000)
		else $error("special event did not clear the timer");
	a_no_ovf_flag: assert property (@(posedge clk_sys) disable iff (reset)
		ce && special && !q.ists[IRQ_OVF] |=> !q.ists[IRQ_OVF])
		else $error("special event set the overflow flag");
	a_write_wins: assert property (@(posedge clk_sys) disable iff (reset)
		ce && special && tw_lo && tw_hi |=> q.timer == $past(q.wdata[15:0]))
		else $error("timer write lost against special event clear");
	a_fault_holds: assert property (@(posedge clk_sys) disable iff (reset)
		ce && fault |=> q.shut[SHUT_EVENT] ##1 (!$past(ce) || q.state != PWM_RUN))
		else $error("fault level did not hold shutdown");
	a_restart_period: assert property (@(posedge clk_sys) disable iff (reset)
		ce && q.state == PWM_WAIT && !per_start |=> q.state != PWM_RUN)
		else $error("pwm resumed before a period start");
	a_irq_level: assert property (@(posedge clk_sys) disable iff (reset)
		ce && |(q.ists & q.imask) |=> irq)
		else $error("unmasked status did not raise irq");
endmodule : ccp_timebase_autoshutdown
`default_nettype wire

// file: verification/fault_stage.sv
// Purpose: far side model, fault sources, capture source, pulled-up pads
// Assumes: bench moves the command inputs just after clk_sys edges
// Notes: a released pwm pad reads high through the port pull-up
`timescale 1ns/1ps
`default_nettype none
module fault_stage (
	input wire logic ext_fault,
	input wire logic b4_fault,
	input wire logic cap_lvl,
	input wire logic [3:0] drv,
	input wire logic [3:0] oe,
	output logic ext_int_pin,
	output logic pin_b4,
	output logic capture_pin,
	output logic [3:0] pad
);
	// ====================
	// fault lines, active low levels
	assign ext_int_pin = ~ext_fault;
	assign pin_b4 = ~b4_fault;
	assign capture_pin = cap_lvl;
	// never leave a floating pad to the simulator's choice
	assign pad = (drv & oe) | ~oe;
endmodule : fault_stage
`default_nettype wire

// file: verification/ccp_timebase_autoshutdown_tb.sv
// Purpose: self-checking bench for the capture/compare and auto-shutdown block
// Assumes: ce held high except in one freeze check; far side model drives fault and capture pins
// Notes: compare period and timer write values come from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module ccp_timebase_autoshutdown_tb import ccp_pkg::*;;
	// ====================
	// signals
	logic clk_sys = 1'h0;
	logic reset = 1'h1;
	logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
	logic bready = 1'h1, rready = 1'h1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic ext_f = 1'h0, b4_f = 1'h0, cap = 1'h0;
	logic ce = 1'h1;
	logic awready, wready, bvalid, arready, rvalid, irq, ext_pin, b4_pin, cap_pin;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [3:0] drv, oe, pad;
	int mismatches = 0;
	int comparisons = 0;
	int seed = 32'h1936;
	// timer only ever counts on clk_sys
	always #20 clk_sys = ~clk_sys;
	ccp_timebase_autoshutdown dut (
		.clk_sys(clk_sys), .reset(reset), .ce(ce),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.capture_pin(cap_pin), .ext_int_pin(ext_pin), .pin_b4(b4_pin), .irq(irq),
		.pwm_out_a(drv[0]), .pwm_oe_a(oe[0]), .pwm_out_b(drv[1]), .pwm_oe_b(oe[1]),
		.pwm_out_c(drv[2]), .pwm_oe_c(oe[2]), .pwm_out_d(drv[3]), .pwm_oe_d(oe[3])
	);
	fault_stage far_side (
		.ext_fault(ext_f), .b4_fault(b4_f), .cap_lvl(cap), .drv(drv), .oe(oe),
		.ext_int_pin(ext_pin), .pin_b4(b4_pin), .capture_pin(cap_pin), .pad(pad)
	);
	// ====================
	// checks and bus cycles
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	task automatic hang();
		mismatches++;
		$display("[FAIL] wait expected answer seen timeout");
		stop_test();
	endtask : hang
	// readies sampled mid-cycle, so each release lands on its taking edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, b;
		logic [1:0] r;
		int n;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		n = 0;
		do begin
			@(negedge clk_sys);
			ta = awvalid & awready;
			tw = wvalid & wready;
			b = bvalid;
			r = bresp;
			@(posedge clk_sys);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
			n++;
		end while (!b && n < 100);
		if (!b) hang();
		chk("bresp", 32'(RESP_OKAY), 32'(r));
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		logic ta, g;
		logic [1:0] r;
		int n;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'h1;
		n = 0;
		do begin
			@(negedge clk_sys);
			ta = arvalid & arready;
			g = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk_sys);
			if (ta) arvalid <= 1'h0;
			n++;
		end while (!g && n < 100);
		if (!g) hang();
		chk("rresp", 32'(er), 32'(r));
	endtask : rd
	// code 1x releases the pair, the pull-up then shows high
	task automatic chk_pins(input logic [1:0] ac, input logic [1:0] bd);
		chk("pin enables", 32'({~bd[1], ~ac[1], ~bd[1], ~ac[1]}), 32'(oe));
		chk("pad levels", 32'({|bd, |ac, |bd, |ac}), 32'(pad));
	endtask : chk_pins
	// ====================
	// sequence
	initial begin
		logic [31:0] v, t0, t1;
		logic [15:0] per;
		int i, c, hi;
		repeat (6) @(posedge clk_sys);
		reset <= 1'h0;
		repeat (3) @(negedge clk_sys);
		chk_pins(2'h0, 2'h1);
		for (i = 0; i < 8; i++) begin
			rd(8'(i * 4), RESP_OKAY, v);
			chk("reset value", (i == 4) ? 32'(PER_RESET) : 32'h0, v);
		end
		rd(8'h20, RESP_SLVERR, v);
		chk("unmapped data", 32'h0, v);
		// plain compare overflows, special trigger must not
		for (c = 2; c < 4; c++) begin
			wr(OFF_CTRL, 32'h0);
			wr(OFF_ISTS, 32'h7);
			wr(OFF_TIMER, 32'hfff0);
			wr(OFF_CMP, 32'hffff);
			wr(OFF_CTRL, 32'(c * 2 + 1));
			repeat (40) @(posedge clk_sys);
			rd(OFF_ISTS, RESP_OKAY, v);
			chk("overflow flag", 32'(c == 2), 32'(v[IRQ_OVF]));
			chk("match flag", 32'h1, 32'(v[IRQ_CCP]));
		end
		@(negedge clk_sys);
		chk("irq masked", 32'h0, 32'(irq));
		wr(OFF_IMASK, 32'h2);
		repeat (2) @(negedge clk_sys);
		chk("irq unmasked", 32'h1, 32'(irq));
		per = 16'(4 + ($random(seed) & 7));
		wr(OFF_TIMER, 32'h0);
		wr(OFF_CMP, 32'(per));
		wr(OFF_CTRL, 32'h7);
		hi = 0;
		for (i = 0; i < 30; i++) begin
			rd(OFF_TIMER, RESP_OKAY, v);
			if (v > hi) hi = v;
		end
		chk("timer peak", 32'h1, 32'(hi <= per && hi > 1));
		// sweep the write across every phase of the clearing period
		for (i = 0; i <= per; i++) begin
			wr(OFF_CTRL, 32'h0);
			wr(OFF_TIMER, 32'h0);
			wr(OFF_CTRL, 32'h7);
			repeat (i) @(posedge clk_sys);
			v = 32'h8000 | (32'($random(seed)) & 32'hfff);
			wr(OFF_TIMER, v);
			rd(OFF_TIMER, RESP_OKAY, t0);
			chk("timer write", 32'h1, 32'(t0 >= v && t0 < v + 16));
		end
		// ce low must freeze the count and hold every ready low
		rd(OFF_TIMER, RESP_OKAY, t0);
		ce <= 1'h0;
		repeat (19) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("readies frozen", 32'h0, 32'({awready, wready, arready}));
		@(posedge clk_sys);
		ce <= 1'h1;
		rd(OFF_TIMER, RESP_OKAY, t1);
		chk("timer frozen", t0 + 32'h3, t1);
		for (c = 1; c >= 0; c--) begin
			wr(OFF_CTRL, 32'(3 + c * 8));
			rd(OFF_TIMER, RESP_OKAY, t0);
			cap <= 1'(c);
			repeat (8) @(posedge clk_sys);
			rd(OFF_TIMER, RESP_OKAY, t1);
			rd(OFF_CMP, RESP_OKAY, v);
			chk("captured time", 32'h1, 32'(v > t0 && v < t1));
		end
		wr(OFF_CTRL, 32'h0);
		wr(OFF_ISTS, 32'h7);
		wr(OFF_IMASK, 32'h4);
		for (c = 0; c < 4; c++) begin
			v = (c % 2 ? 32'h10 : 32'h40) | 32'(c * 4 + 3 - c);
			wr(OFF_SHUT, v);
			ext_f <= (c % 2 == 0);
			b4_f <= (c % 2 == 1);
			repeat (8) @(negedge clk_sys);
			chk_pins(2'(c), 2'(3 - c));
			chk("shutdown irq", 32'h1, 32'(irq));
			wr(OFF_SHUT, v);
			rd(OFF_SHUT, RESP_OKAY, t0);
			chk("flag kept", v | 32'h80, t0);
			ext_f <= 1'h0;
			b4_f <= 1'h0;
			repeat (8) @(posedge clk_sys);
			wr(OFF_SHUT, v);
			@(negedge clk_sys);
			chk_pins(2'(c), 2'(3 - c));
			for (i = 0; i < 600 && !(oe === 4'hf && pad === 4'ha); i++) @(negedge clk_sys);
			if (i == 600) hang();
			wr(OFF_ISTS, 32'h4);
			repeat (3) @(negedge clk_sys);
			chk("irq cleared", 32'h0, 32'(irq));
		end
		// auto-restart drops the flag once the fault level is gone
		wr(OFF_CTRL, 32'h10);
		wr(OFF_SHUT, 32'h40);
		ext_f <= 1'h1;
		repeat (8) @(posedge clk_sys);
		ext_f <= 1'h0;
		repeat (8) @(posedge clk_sys);
		rd(OFF_SHUT, RESP_OKAY, v);
		chk("auto restart", 32'h40, v);
		// reset in mid-run
		reset <= 1'h1;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("oe in reset", 32'h0, 32'(oe));
		@(posedge clk_sys);
		reset <= 1'h0;
		rd(OFF_SHUT, RESP_OKAY, v);
		chk("shut after reset", 32'(SHUT_RESET), v);
		stop_test();
	end
endmodule : ccp_timebase_autoshutdown_tb
`default_nettype wire
